// ==== core/sfcs_host.sv ====
// sfcs_host.sv: apb-programmed spi master that runs command frames on a serial flash
// assumes: one spi device on the select; link clock made here by a divider of core_clk
// Notes on behaviour
// R01: read word is 15h, three address bytes, one dummy, two data back, seven bytes.
// R02: auto read is 16h, one dummy, two data back, four bytes.
// R03: write word is 17h, three address, two data, one dummy, seven bytes.
// R04: auto write is 18h, two data, one dummy, four bytes.
// R05: erase 19h and validate 1A carry three address bytes and one dummy, five bytes.
// R06: status word read is 22, no address or dummy, two bytes back, three bytes.
// R07: config write is 1D, three address, two data, one dummy, seven bytes.
// R08: config read is 1E, three address, one dummy, two data back, seven bytes.
// R09: special command is 1F, two data bytes and one dummy, four bytes.
// R10: every multi-byte field travels most significant byte first.
// R11: dummy counts include input bytes overlapping returned output bytes.
// R12: quick status resets to zero; bits flag frame error, busy kinds.
// R13: device sets quick status bit 2 on a one written over a zero.
// R14: device sets quick status bit 1 on a read of unavailable data.
// R15: device sets quick status bit 0 after a failed erase or program.
// R16: status word holds zeros, revision field, and seven busy and error bits.
// R17: command-failure and invalid-data flags stay set until the host clears them.
// R18: clearing is special command 1F with data 00 40 and a dummy byte.
// R19: sticky flags reach quick status one transaction late.
// R20: device busy stays in quick status until the second later transaction.
// R21: frame error and read error apply only to the preceding transaction.
// R22: host should poll quick status twice after each command.
// R23: auto reads and writes advance the device address by one first.
// R24: data is sampled on rising link clock and launched on falling edge.
// R25: quick status byte comes out during the first eight clocks of a frame.
// R26: device ignores unknown commands and clocks beyond the frame length.
// R27: a frame runs from select falling low until select returns high.
`timescale 1ns/1ns

module sfcs_host #(
  parameter int DIV_W = 8
) (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state but the reset synchroniser while low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on read of an unmapped address
  output logic sck, // link clock to the device
  output logic cs_n, // active low device select
  output logic si, // serial data to the device
  input wire logic so, // serial data from the device
  output logic busy // frame in progress
);

  logic rst_s1_reg;
  logic rst_n_reg;
  logic so_s1_reg;
  logic so_s2_reg;
  sfcs_pkg::sfcs_apb_req_s req;
  sfcs_pkg::sfcs_frame_s frm;
  sfcs_pkg::sfcs_state_e state_reg;
  logic [7:0] op_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] qstat_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] gap_cnt_reg;
  logic done_reg;
  logic badop_reg;
  logic go;
  logic apb_wr;
  logic apb_rd;
  logic half_tick;
  logic rise_tick;
  logic fall_tick;
  logic [7:0] rx_byte;
  logic [7:0] tx_next;
  logic [7:0] op_cur;
  logic start;
  logic byte_end;
  logic last_byte;
  logic [2:0] nxt_idx;
  logic [2:0] data_idx;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // reset release through two flops; the rest of the design uses rst_n_reg
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // device output crosses into core_clk before anything reads it
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
    end else if (clk_en) begin
      so_s1_reg <= so;
      so_s2_reg <= so_s1_reg;
    end
  end

  // frame shape per command; unknown codes are refused, never sent
  always_comb begin
    frm = '{n_addr: 3'h0, n_data_in: 2'h0, n_dummy: 2'h0, n_data_out: 2'h0, n_total: 3'h0};
    case (op_cur)
      `SFCS_CMD_RD, `SFCS_CMD_CFG_RD:
        frm = '{3'h3, 2'h0, 2'h1, 2'h2, 3'h7}; // [R01] [R08] [R11]
      `SFCS_CMD_RD_AUTO:
        frm = '{3'h0, 2'h0, 2'h1, 2'h2, 3'h4}; // [R02] [R23]
      `SFCS_CMD_WR, `SFCS_CMD_CFG_WR:
        frm = '{3'h3, 2'h2, 2'h1, 2'h0, 3'h7}; // [R03] [R07]
      `SFCS_CMD_WR_AUTO, `SFCS_CMD_SPECIAL:
        frm = '{3'h0, 2'h2, 2'h1, 2'h0, 3'h4}; // [R04] [R09] [R18]
      `SFCS_CMD_ERASE, `SFCS_CMD_VALID:
        frm = '{3'h3, 2'h0, 2'h1, 2'h0, 3'h5}; // [R05]
      `SFCS_CMD_STATUS:
        frm = '{3'h0, 2'h0, 2'h0, 2'h2, 3'h3}; // [R06]
      default: ;
    endcase
  end

  // byte to send after byte index byte_cnt_reg: command, address, data, then zero dummies
  // data is indexed from the end of the address part, so frames without address
  // take their data straight after the command and never leak address bits as dummies
  always_comb begin
    tx_next = 8'h00;
    if (nxt_idx <= frm.n_addr) begin
      case (nxt_idx)
        3'h1: tx_next = addr_reg[23:16]; // [R10]
        3'h2: tx_next = addr_reg[15:8];
        default: tx_next = addr_reg[7:0];
      endcase
    end else if (data_idx < {1'b0, frm.n_data_in}) begin
      tx_next = (data_idx == 3'h0) ? wdata_reg[15:8] : wdata_reg[7:0]; // [R10]
    end
  end

  assign apb_wr = req.psel && req.penable && req.pwrite;
  // setup phase of a read: only reads of unmapped offsets answer with an error
  assign apb_rd = req.psel && !req.penable && !req.pwrite;
  // a go write carries its own opcode; decoding the stored one would start the previous frame
  assign op_cur = go ? req.pwdata[`SFCS_CTRL_OP_MSB:`SFCS_CTRL_OP_LSB] : op_reg;
  assign start = go && frm.n_total != 3'h0;
  assign byte_end = fall_tick && bit_cnt_reg == 3'h7;
  assign last_byte = byte_end && byte_cnt_reg + 3'h1 == frm.n_total;
  assign nxt_idx = byte_cnt_reg + 3'h1;
  assign data_idx = nxt_idx - frm.n_addr - 3'h1;
  assign go = apb_wr && req.paddr == `SFCS_OFF_CTRL && req.pwdata[`SFCS_CTRL_GO_BIT]
              && state_reg == sfcs_pkg::SFCS_IDLE;
  assign half_tick = state_reg == sfcs_pkg::SFCS_SHIFT && div_cnt_reg == '0;
  assign rise_tick = half_tick && !sck;
  assign fall_tick = half_tick && sck;
  assign rx_byte = {rx_sh_reg[6:0], so_s2_reg};

  // apb slave: zero wait states, pready high in every access phase
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= req.psel && !req.penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (req.psel && !req.penable) begin
        case (req.paddr)
          `SFCS_OFF_CTRL: prdata <= {24'h00_0000, op_reg};
          `SFCS_OFF_ADDR: prdata <= {8'h00, addr_reg};
          `SFCS_OFF_WDATA: prdata <= {16'h0000, wdata_reg};
          `SFCS_OFF_STAT: prdata <= {29'h0000_0000, badop_reg, done_reg, busy};
          `SFCS_OFF_RDATA: prdata <= {16'h0000, rdata_reg};
          `SFCS_OFF_QSTAT: prdata <= {24'h00_0000, qstat_reg}; // [R12] [R22]
          `SFCS_OFF_DIV: prdata <= {{(32-DIV_W){1'b0}}, div_reg};
          default: pslverr <= apb_rd;
        endcase
      end
    end
  end

  // software-written settings; writes ignored while a frame runs
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      op_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      wdata_reg <= 16'h0000;
      div_reg <= DIV_W'(`SFCS_RST_DIV);
    end else if (clk_en && apb_wr && state_reg == sfcs_pkg::SFCS_IDLE) begin
      case (req.paddr)
        `SFCS_OFF_CTRL: op_reg <= req.pwdata[`SFCS_CTRL_OP_MSB:`SFCS_CTRL_OP_LSB];
        `SFCS_OFF_ADDR: addr_reg <= req.pwdata[23:0];
        `SFCS_OFF_WDATA: wdata_reg <= req.pwdata[15:0];
        `SFCS_OFF_DIV: div_reg <= (req.pwdata[DIV_W-1:0] == '0) ? DIV_W'(1) : req.pwdata[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // link clock divider; runs only while shifting, so sck stands still low between frames
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      div_cnt_reg <= '0;
      sck <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        div_cnt_reg <= div_reg;
      end else if (state_reg == sfcs_pkg::SFCS_SHIFT) begin
        div_cnt_reg <= half_tick ? div_reg : div_cnt_reg - DIV_W'(1);
        if (rise_tick) begin
          sck <= 1'b1; // device samples si here [R24]
        end
        if (fall_tick) begin
          sck <= 1'b0;
        end
      end
    end
  end

  // serial shifter: inside a frame si moves on the falling link clock only, the first bit at frame start; it clears to zero in the gap
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      si <= 1'b0;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      tx_byte_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
    end else if (clk_en) begin
      if (start) begin
        si <= op_cur[7];
        tx_byte_reg <= {op_cur[6:0], 1'b0};
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 3'h0;
      end else if (state_reg == sfcs_pkg::SFCS_GAP) begin
        si <= 1'b0;
      end
      if (rise_tick) begin
        rx_sh_reg <= rx_byte;
      end
      if (fall_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_end) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        if (!byte_end) begin
          si <= tx_byte_reg[7];
          tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
        end else if (!last_byte) begin
          si <= tx_next[7]; // [R10]
          tx_byte_reg <= {tx_next[6:0], 1'b0};
        end
      end
    end
  end

  // framing: select low for the whole frame, then a gap with select high before idle
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= sfcs_pkg::SFCS_IDLE;
      cs_n <= 1'b1;
      busy <= 1'b0;
      gap_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        sfcs_pkg::SFCS_IDLE: begin
          if (start) begin
            state_reg <= sfcs_pkg::SFCS_SHIFT;
            cs_n <= 1'b0; // [R27]
            busy <= 1'b1;
          end
        end
        sfcs_pkg::SFCS_SHIFT: begin
          if (last_byte) begin
            state_reg <= sfcs_pkg::SFCS_GAP; // no clocks past frame end [R26]
            gap_cnt_reg <= 8'(`SFCS_CS_IDLE_CYC);
          end
        end
        sfcs_pkg::SFCS_GAP: begin
          cs_n <= 1'b1; // [R27]
          gap_cnt_reg <= gap_cnt_reg - 8'h01;
          if (gap_cnt_reg == 8'h00) begin
            state_reg <= sfcs_pkg::SFCS_IDLE;
            busy <= 1'b0;
          end
        end
        default: state_reg <= sfcs_pkg::SFCS_IDLE;
      endcase
    end
  end

  // capture of returned bytes: quick status first, result msb first
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      qstat_reg <= `SFCS_RST_QS; // [R12]
      rdata_reg <= 16'h0000;
    end else if (clk_en && rise_tick && bit_cnt_reg == 3'h7) begin
      if (byte_cnt_reg == 3'h0) begin
        qstat_reg <= rx_byte; // [R25] [R19] [R20] [R21]
      end else if (frm.n_data_out != 2'h0 && byte_cnt_reg == frm.n_total - 3'h2) begin
        rdata_reg[15:8] <= rx_byte; // [R10] [R11]
      end else if (frm.n_data_out != 2'h0 && byte_cnt_reg == frm.n_total - 3'h1) begin
        rdata_reg[7:0] <= rx_byte;
      end
    end
  end

  // done is set by frame end and cleared by any go write, refused ones included; refused ops are flagged
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      done_reg <= 1'b0;
      badop_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == sfcs_pkg::SFCS_GAP && gap_cnt_reg == 8'h00) begin
        done_reg <= 1'b1;
      end else if (go) begin
        done_reg <= 1'b0;
      end
      if (go) begin
        badop_reg <= frm.n_total == 3'h0;
      end
    end
  end

endmodule

// ==== core/sfcs_map.svh ====
// sfcs_map.svh: offsets, field positions, reset values and timing counts for the host controller
// assumes: included by bare name from the package and the bench
`ifndef SFCS_MAP_SVH
`define SFCS_MAP_SVH

// own apb register offsets (byte addresses)
`define SFCS_OFF_CTRL 12'h000
`define SFCS_OFF_ADDR 12'h004
`define SFCS_OFF_WDATA 12'h008
`define SFCS_OFF_STAT 12'h00C
`define SFCS_OFF_RDATA 12'h010
`define SFCS_OFF_QSTAT 12'h014
`define SFCS_OFF_DIV 12'h018

// ctrl register fields
`define SFCS_CTRL_GO_BIT 8
`define SFCS_CTRL_OP_LSB 0
`define SFCS_CTRL_OP_MSB 7

// stat register fields
`define SFCS_STAT_BUSY_BIT 0
`define SFCS_STAT_DONE_BIT 1
`define SFCS_STAT_BADOP_BIT 2

// command bytes
`define SFCS_CMD_RD 8'h15
`define SFCS_CMD_RD_AUTO 8'h16
`define SFCS_CMD_WR 8'h17
`define SFCS_CMD_WR_AUTO 8'h18
`define SFCS_CMD_ERASE 8'h19
`define SFCS_CMD_VALID 8'h1A
`define SFCS_CMD_CFG_WR 8'h1D
`define SFCS_CMD_CFG_RD 8'h1E
`define SFCS_CMD_SPECIAL 8'h1F
`define SFCS_CMD_STATUS 8'h22

// clear-errors payload of the special command
`define SFCS_CLR_WORD 16'h0040

// quick status bits
`define SFCS_QS_FRAME_BIT 6
`define SFCS_QS_WBUSY_BIT 5
`define SFCS_QS_EBUSY_BIT 4
`define SFCS_QS_DBUSY_BIT 3
`define SFCS_QS_INVAL_BIT 2
`define SFCS_QS_RDERR_BIT 1
`define SFCS_QS_CMDERR_BIT 0

// status word fields
`define SFCS_SW_REV_LSB 8
`define SFCS_SW_REV_MSB 11

// reset values
`define SFCS_RST_DIV 8'h08
`define SFCS_RST_QS 8'h00

// select idle time between frames: least time in ns, rounded up to clock cycles
`define SFCS_CLK_NS 4
`define SFCS_CS_IDLE_NS 40
`define SFCS_CS_IDLE_CYC ((`SFCS_CS_IDLE_NS + `SFCS_CLK_NS - 1) / `SFCS_CLK_NS)

`endif

// ==== core/sfcs_pkg.sv ====
// sfcs_pkg.sv: types shared by the serial flash host controller
// assumes: sfcs_map.svh sits beside it on the include path
`include "sfcs_map.svh"

package sfcs_pkg;

  // byte counts of one frame as sent on the link
  typedef struct packed {
    logic [2:0] n_addr;
    logic [1:0] n_data_in;
    logic [1:0] n_dummy;
    logic [1:0] n_data_out;
    logic [2:0] n_total;
  } sfcs_frame_s;

  // apb slave signals from the bus
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sfcs_apb_req_s;

  typedef enum logic [1:0] {
    SFCS_IDLE,
    SFCS_SHIFT,
    SFCS_GAP
  } sfcs_state_e;

endpackage

// ==== test/sfcs_dev_model.sv ====
// sfcs_dev_model.sv: behavioural flash command front end, spi mode 0 slave
// assumes: one host drives sck, cs_n, si; word array cut to 256 entries
`timescale 1ns/1ns
module sfcs_dev_model #(
  parameter logic [3:0] REV = 4'h6 // arbitrary revision value
) (
  input wire logic sck, // link clock
  input wire logic cs_n, // select, active low
  input wire logic si, // data from host
  output logic so // data to host
);
  logic [15:0] mem [0:255];
  logic [255:0] wr = '0;
  logic [55:0] rx;
  logic [23:0] adr = '0;
  logic [15:0] cfg = '0, rd, wd;
  logic [7:0] qs, cmd;
  logic inv = 0, cer = 0, ci = 0, cc = 0, bsy = 0, rde = 0;
  int n;
  function automatic int flen(input logic [7:0] c);
    case (c)
      8'h15, 8'h17, 8'h1D, 8'h1E: return 56;
      8'h16, 8'h18, 8'h1F: return 32;
      8'h19, 8'h1A: return 40;
      8'h22: return 24;
      default: return 0;
    endcase
  endfunction
  initial so = 1'b0;
  // sticky flags shown one frame late, busy and read error shown once
  always @(negedge cs_n) begin
    n = 0;
    qs = {4'h0, bsy, ci, rde, cc};
    {ci, cc, bsy, rde} = {inv, cer, 2'b00};
    so = qs[7];
  end
  always @(posedge sck) if (!cs_n) begin
    rx = {rx[54:0], si};
    n++;
    if (n == 8) cmd = rx[7:0];
    if (n == 8 && cmd == 8'h16) adr = adr + 24'h1;
    if (n == 32 && cmd inside {8'h15, 8'h17, 8'h19, 8'h1A}) adr = rx[23:0];
    if ((n == 8 && cmd inside {8'h16, 8'h22}) || (n == 32 && cmd inside {8'h15, 8'h1E})) begin
      rd = cmd == 8'h22 ? {4'h0, REV, 8'h00} : cmd == 8'h1E ? cfg :
        wr[adr[7:0]] ? mem[adr[7:0]] : 16'h0000;
      rde = cmd inside {8'h15, 8'h16} && !wr[adr[7:0]];
    end
  end
  always @(negedge sck) if (!cs_n) begin
    if (n < 8) so = qs[7 - n];
    else if (cmd inside {8'h15, 8'h16, 8'h1E, 8'h22} && n < flen(cmd) && n >= flen(cmd) - 16)
      so = rd[flen(cmd) - 1 - n];
    else so = ~so;
  end
  always @(posedge cs_n) begin
    wd = rx[23:8];
    if (n >= flen(cmd)) case (cmd)
      8'h17, 8'h18: begin
        if (cmd == 8'h18) adr = adr + 24'h1;
        if (wr[adr[7:0]] && |(wd & ~mem[adr[7:0]])) inv = 1'b1;
        else begin
          mem[adr[7:0]] = wd;
          wr[adr[7:0]] = 1'b1;
        end
        bsy = 1'b1;
      end
      8'h19: begin
        cer = cer | adr[23];
        bsy = 1'b1;
      end
      8'h1D: cfg = wd;
      8'h1F: if (wd == 16'h0040) {inv, cer} = 2'b00;
      default: ;
    endcase
    so = ~so;
  end
endmodule

// ==== test/sfcs_host_properties.sv ====
// sfcs_host_properties.sv: timing checks on the host controller ports
// assumes: bound into sfcs_host; link runs in mode 0
`timescale 1ns/1ns
module sfcs_host_props (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic sck, // link clock
  input wire logic cs_n, // device select
  input wire logic si, // data to device
  input wire logic busy // frame flag
);
  default clocking dck @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic sck_reg;
  logic [7:0] bits_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_reg <= 1'b0;
      bits_reg <= 8'h00;
    end else begin
      sck_reg <= sck;
      if (cs_n) bits_reg <= 8'h00;
      else if (sck && !sck_reg) bits_reg <= bits_reg + 8'h01;
    end
  end
  frame_len_a: assert property (
    $rose(cs_n) |-> bits_reg inside {8'h18, 8'h20, 8'h28, 8'h38})
    else $error("frame bit count wrong");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("link clock not idle low");
  si_hold_a: assert property ($rose(sck) |-> $stable(si))
    else $error("data moved at rising edge");
  si_launch_a: assert property (
    $changed(si) && !cs_n |-> $fell(sck) || $fell(cs_n))
    else $error("data moved off falling edge");
  sck_half_a: assert property ($changed(sck) |=> $stable(sck))
    else $error("link clock half period too short");
  frame_busy_a: assert property (!cs_n |-> busy)
    else $error("busy low inside frame");
  frame_gap_a: assert property ($rose(cs_n) |=> cs_n [*8])
    else $error("select gap too short");
  zero_wait_a: assert property (psel && $rose(penable) |-> pready)
    else $error("access phase not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_read_a: assert property (pslverr |-> pready && !pwrite)
    else $error("error outside read answer");
  cover property ($rose(cs_n) && bits_reg == 8'h38);
  cover property ($rose(cs_n) && bits_reg == 8'h18);
  cover property (pslverr);
endmodule

// ==== test/tb.sv ====
// tb.sv: self-checking bench, apb tasks driving the host against the device model
// assumes: package, host, device model and checker compiled first
`timescale 1ns/1ns
`include "sfcs_map.svh"
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb;
  localparam logic [3:0] REV = 4'h6; // arbitrary revision value
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  sfcs_pkg::sfcs_apb_req_s req = '0;
  logic psel, penable, pwrite, so, pready, pslverr, sck, cs_n, si, busy, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic clk_en = 1'b1;
  logic [2:0] fz;
  int err_total = 0;
  int tests_run = 0;
  assign {psel, penable, pwrite, paddr, pwdata} = req;
  always #2 core_clk = ~core_clk;
  sfcs_host dut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .busy(busy)
  );
  sfcs_dev_model #(.REV(REV)) dev (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    req <= '0;
  endtask
  task automatic fr(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d,
    input logic [7:0] q, input logic chk, input logic [15:0] r);
    apb(1'b1, `SFCS_OFF_ADDR, {8'h00, a});
    apb(1'b1, `SFCS_OFF_WDATA, {16'h0000, d});
    apb(1'b1, `SFCS_OFF_CTRL, {23'h0, 1'b1, c});
    do apb(1'b0, `SFCS_OFF_STAT, 32'h0); while (rv[1:0] !== 2'b10);
    apb(1'b0, `SFCS_OFF_QSTAT, 32'h0);
    `CHK("qstat", {24'h0, q}, rv)
    if (chk) begin
      apb(1'b0, `SFCS_OFF_RDATA, 32'h0);
      `CHK("rdata", {16'h0, r}, rv)
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, `SFCS_OFF_DIV, 32'h0);
    `CHK("div", {24'h0, `SFCS_RST_DIV}, rv)
    apb(1'b0, `SFCS_OFF_QSTAT, 32'h0);
    `CHK("qstat", {24'h0, `SFCS_RST_QS}, rv)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("slverr", 1'b1, se)
    apb(1'b1, `SFCS_OFF_DIV, 32'h3);
    $display("reset test done");
    fr(8'h17, 24'h000012, 16'hA5C3, 8'h00, 1'b0, 16'h0);
    fr(8'h18, 24'h000012, 16'h1234, 8'h08, 1'b0, 16'h0);
    fr(8'h15, 24'h000012, 16'h0, 8'h08, 1'b1, 16'hA5C3);
    fr(8'h16, 24'h000012, 16'h0, 8'h00, 1'b1, 16'h1234);
    fr(8'h16, 24'h000012, 16'h0, 8'h00, 1'b0, 16'h0);
    fr(8'h22, 24'h0, 16'h0, 8'h02, 1'b1, {4'h0, REV, 8'h00});
    fr(8'h22, 24'h0, 16'h0, 8'h00, 1'b0, 16'h0);
    fr(8'h17, 24'h000012, 16'hFFFF, 8'h00, 1'b0, 16'h0);
    fr(8'h19, 24'h800000, 16'h0, 8'h08, 1'b0, 16'h0);
    fr(8'h22, 24'h0, 16'h0, 8'h0C, 1'b0, 16'h0);
    fr(8'h22, 24'h0, 16'h0, 8'h05, 1'b0, 16'h0);
    fr(8'h1F, 24'h0, `SFCS_CLR_WORD, 8'h05, 1'b0, 16'h0);
    fr(8'h22, 24'h0, 16'h0, 8'h05, 1'b0, 16'h0);
    fr(8'h22, 24'h0, 16'h0, 8'h00, 1'b0, 16'h0);
    fr(8'h1D, 24'h008006, 16'h0654, 8'h00, 1'b0, 16'h0);
    fr(8'h1E, 24'h008006, 16'h0, 8'h00, 1'b1, 16'h0654);
    fr(8'h1A, 24'h000012, 16'h0, 8'h00, 1'b0, 16'h0);
    $display("frame test done");
    apb(1'b1, `SFCS_OFF_CTRL, {23'h0, 1'b1, 8'h33});
    apb(1'b0, `SFCS_OFF_STAT, 32'h0);
    `CHK("badop", 1'b1, rv[2])
    $display("unknown op test done");
    apb(1'b1, `SFCS_OFF_CTRL, {23'h0, 1'b1, `SFCS_CMD_RD});
    apb(1'b1, `SFCS_OFF_ADDR, 32'h0000_0077);
    apb(1'b0, `SFCS_OFF_ADDR, 32'h0);
    `CHK("addr held", 32'h0000_0012, rv)
    clk_en <= 1'b0;
    @(posedge core_clk);
    fz = {sck, cs_n, si};
    repeat (40) @(posedge core_clk);
    `CHK("frozen link", fz, {sck, cs_n, si})
    `CHK("frozen select", 1'b0, cs_n)
    clk_en <= 1'b1;
    do apb(1'b0, `SFCS_OFF_STAT, 32'h0); while (rv[1:0] !== 2'b10);
    apb(1'b0, `SFCS_OFF_RDATA, 32'h0);
    `CHK("rdata", 32'h0000_A5C3, rv)
    $display("freeze test done");
    final_report();
  end
endmodule
bind sfcs_host sfcs_host_props chk (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si), .busy(busy)
);
